// File: dag_pkg.sv
// Constants, field positions and enumerations shared by the debug access gate.
`default_nettype none
package dag_pkg;
  // Register bus byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IRQ_ST = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
  // Control register fields and their reset value.
  localparam int CTRL_W = 4;
  localparam int CTRL_OS_LOCK_CONDITION = 0;
  localparam int CTRL_DLK = 1;
  localparam int CTRL_HALT = 2;
  localparam int CTRL_EXC = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h1;
  // Status register fields.
  localparam int STAT_SDAD = 0;
  localparam int STAT_OFF = 1;
  localparam int STAT_AUTH = 2;
  localparam int STAT_OS_LOCK_CONDITION = 3;
  localparam int STAT_DLK = 4;
  localparam int STAT_W = 5;
  // Interrupt event bits.
  localparam int EV_SDAD = 0;
  localparam int EV_REJ = 1;
  localparam int EV_WP = 2;
  localparam int NEV = 3;
  localparam logic [NEV-1:0] EV_RST = 3'h0;
  // Debug port register window.
  localparam int APB_AW = 12;
  localparam logic [1:0] APB_IDX_STAT = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Kinds of memory operation reported by the core.
  typedef enum logic [2:0] {
    K_LOAD = 3'h0, K_STORE = 3'h1, K_HINT = 3'h2, K_CLEAN = 3'h3,
    K_ZVA = 3'h4, K_IVAC = 3'h5, K_STREX = 3'h6, K_CAS = 3'h7
  } dag_kind_e;
  // Outcome of the permission check, one-hot.
  typedef enum logic [4:0] {
    G_DEFAULT = 5'b00001, G_OFF = 5'b00010, G_DLK = 5'b00100,
    G_OS_LOCK_CONDITION = 5'b01000, G_DEBUG_ACCESS_DISABLED_CONDITION = 5'b10000
  } dag_gate_e;
  // Debug port transfer state, one-hot.
  typedef enum logic [1:0] {
    A_IDLE = 2'b01, A_RESP = 2'b10
  } dag_apb_e;
endpackage : dag_pkg
`default_nettype wire

// File: dag_gate.sv
// Debug access gate: permission checks on the debug port and watchpoint event steering.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1 - Judge each debug port access on conditions present during that access.
// RQ2 - Core power off or unreachable: every debug port access returns an error.
// RQ3 - Double lock condition holds whenever the double lock status bit is 1.
// RQ4 - Check power off, double lock, OS lock, disabled, default; first true decides.
// RQ5 - OS lock condition holds when OS lock bit is 1, ranked third.
// RQ6 - Unauthorised access as top failure errors and sets sticky access-disabled flag; a status index access is exempt and does neither.
// RQ7 - With no condition true the access reads or writes normally.
// RQ8 - Each debug event is ignored, taken as exception, or enters halted state.
// RQ9 - Watchpoint events are raised synchronously with their causing instruction.
// RQ10 - Hints and cache cleans raise no watchpoint, except zero-by-address and invalidate.
// RQ11 - Matching exclusive store raises a watchpoint even if the monitor check fails.
// RQ12 - Matching compare-and-swap raises a watchpoint even if comparison fails.
// RQ13 - Cold reset engages the OS lock.
// RQ14 - Software or debugger clears the OS lock before normal debug use; only a register bus write clears it, the debug port cannot.
// RQ15 - Warm reset leaves locks and sticky flags alone; only cold reset does.
// RQ16 - Rejected access ends with slave error; rejected write changes nothing.
module dag_gate
  import dag_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic warm_reset_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_power_off,
  input wire logic external_access_authorised,
  input wire logic mem_valid,
  input wire logic [2:0] mem_kind,
  input wire logic wp_match,
  input wire logic [7:0] mem_tag,
  output logic wp_event,
  output logic [7:0] wp_tag,
  output logic dbg_ignore,
  output logic dbg_exception,
  output logic dbg_halt
);

  logic [CTRL_W-1:0] ctrl_r;
  logic sdad_r;
  logic [NEV-1:0] ev_st_r;
  logic [NEV-1:0] ev_en_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  dag_apb_e apb_st_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  // Index 0 is the status word, so the storage array starts at index 1.
  logic [31:0] dbg_mem [1:3];
  dag_gate_e gate;
  logic double_lock_engaged;
  logic os_lock_condition;
  logic apb_take;
  logic [1:0] apb_idx;
  logic stat_reg;
  logic rejected;
  logic [STAT_W-1:0] stat_word;
  logic wb_wr;
  logic wp_hit;
  logic [NEV-1:0] ev_set;
  logic [NEV-1:0] ev_clr;
  logic debug_access_disabled_condition_hit;

  // Lock conditions come straight from the control bits.
  assign double_lock_engaged = ctrl_r[CTRL_DLK]; // RQ3
  assign os_lock_condition = ctrl_r[CTRL_OS_LOCK_CONDITION]; // RQ5
  assign stat_word = {ctrl_r[CTRL_DLK], ctrl_r[CTRL_OS_LOCK_CONDITION], external_access_authorised, core_power_off, sdad_r};

  // A debug port access is judged in the first cycle of its access phase.
  assign apb_take = psel && penable && (apb_st_r == A_IDLE); // RQ1
  assign apb_idx = paddr[3:2];
  assign stat_reg = (apb_idx == APB_IDX_STAT);

  // Conditions are scanned in priority order and the first true one wins.
  always_comb
  begin
    gate = G_DEFAULT; // RQ7
    if (core_power_off)
      gate = G_OFF; // RQ2
    else if (double_lock_engaged)
      gate = G_DLK; // RQ4
    else if (os_lock_condition)
      gate = G_OS_LOCK_CONDITION; // RQ5
    else if (!external_access_authorised)
      gate = G_DEBUG_ACCESS_DISABLED_CONDITION; // RQ6
  end

  // The status word stays readable under every condition except power off.
  assign rejected = (gate != G_DEFAULT) && !(stat_reg && (gate != G_OFF)); // RQ4

  // An authorisation refusal counts only when it is the highest failing condition.
  assign debug_access_disabled_condition_hit = apb_take && rejected && (gate == G_DEBUG_ACCESS_DISABLED_CONDITION); // RQ6

  // Debug port transfer sequencing; the answer comes one cycle into the access phase.
  always_ff @(posedge clk)
  begin
    if (rst)
      apb_st_r <= A_IDLE;
    else
      case (apb_st_r)
        A_IDLE:
          if (apb_take)
            apb_st_r <= A_RESP;
        A_RESP:
          apb_st_r <= A_IDLE;
        default:
          apb_st_r <= A_IDLE;
      endcase
  end

  // Ready comes from the state register, so it stands for exactly one cycle; the answer holds until the next access is judged.
  assign pready = (apb_st_r == A_RESP);
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // Read data and error answer are captured when the access is judged.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_r <= WORD_ZERO;
      pslverr_r <= 1'b0;
    end
    else if (apb_take)
    begin
      pslverr_r <= rejected; // RQ16
      if (rejected || pwrite)
        prdata_r <= WORD_ZERO;
      else if (stat_reg)
        prdata_r <= {{(32-STAT_W){1'b0}}, stat_word};
      else
        prdata_r <= dbg_mem[apb_idx]; // RQ7
    end
  end

  // Debug data words; a refused write leaves them untouched.
  // The status index is read-only and is never stored here.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 1; i <= 3; i++)
        dbg_mem[i] <= WORD_ZERO;
    end
    else if (apb_take && pwrite && !rejected && !stat_reg)
      dbg_mem[apb_idx] <= pwdata; // RQ16
  end

  // Sticky access-disabled flag; only the cold reset clears it besides a status read.
  // The set test comes first, so a refusal is never lost to a clearing read.
  always_ff @(posedge clk)
  begin
    if (rst)
      sdad_r <= 1'b0; // RQ15
    else if (debug_access_disabled_condition_hit)
      sdad_r <= 1'b1; // RQ6
    else if (apb_take && stat_reg && !pwrite && !rejected)
      sdad_r <= 1'b0;
  end

  // Watchpoint qualification: hints and cleans are excluded, failed exclusives and CAS count.
  // A failed store or compare does not matter: the match alone raises the event.
  always_comb
  begin
    case (dag_kind_e'(mem_kind))
      K_HINT, K_CLEAN:
        wp_hit = 1'b0; // RQ10
      K_ZVA, K_IVAC:
        wp_hit = mem_valid && wp_match; // RQ10
      K_STREX, K_CAS:
        wp_hit = mem_valid && wp_match; // RQ11 RQ12
      default:
        wp_hit = mem_valid && wp_match;
    endcase
  end

  // Event and tag are registered together, so the tag belongs to the instruction that raised it.
  // The warm reset clears them as core logic, while locks and flags keep their values.
  always_ff @(posedge clk)
  begin
    if (rst || !warm_reset_n)
    begin
      wp_event <= 1'b0;
      wp_tag <= 8'h00;
    end
    else
    begin
      wp_event <= wp_hit; // RQ9
      wp_tag <= wp_hit ? mem_tag : 8'h00; // RQ9
    end
  end

  // Exactly one response accompanies each event.
  // While either lock is engaged the event is ignored, so software must clear the locks first.
  always_ff @(posedge clk)
  begin
    if (rst || !warm_reset_n)
    begin
      dbg_ignore <= 1'b0;
      dbg_exception <= 1'b0;
      dbg_halt <= 1'b0;
    end
    else
    begin
      dbg_ignore <= 1'b0;
      dbg_exception <= 1'b0;
      dbg_halt <= 1'b0;
      if (wp_hit)
      begin
        if (os_lock_condition || double_lock_engaged)
          dbg_ignore <= 1'b1; // RQ8 RQ14
        else if (ctrl_r[CTRL_HALT])
          dbg_halt <= 1'b1; // RQ8
        else if (ctrl_r[CTRL_EXC])
          dbg_exception <= 1'b1; // RQ8
        else
          dbg_ignore <= 1'b1; // RQ8
      end
    end
  end

  // Register bus: one wait cycle, then ack for one cycle; writes land on the ack edge.
  assign wb_wr = wb_cyc && wb_stb && wb_we && wb_ack_r && wb_sel[0];
  assign wb_ack = wb_ack_r;
  assign wb_dat_o = wb_dat_r;

  // Ack is a one-cycle pulse; a master that holds its strobe sees one ack every other cycle.

  always_ff @(posedge clk)
  begin
    if (rst)
      wb_ack_r <= 1'b0;
    else
      wb_ack_r <= wb_cyc && wb_stb && !wb_ack_r;
  end

  // Read data mux; unmapped and write-only offsets read as zero.
  always_ff @(posedge clk)
  begin
    if (rst)
      wb_dat_r <= WORD_ZERO;
    else if (wb_cyc && wb_stb && !wb_ack_r)
      case (wb_adr)
        OFF_CTRL: wb_dat_r <= {{(32-CTRL_W){1'b0}}, ctrl_r};
        OFF_STAT: wb_dat_r <= {{(32-STAT_W){1'b0}}, stat_word};
        OFF_IRQ_ST: wb_dat_r <= {{(32-NEV){1'b0}}, ev_st_r};
        OFF_IRQ_EN: wb_dat_r <= {{(32-NEV){1'b0}}, ev_en_r};
        default: wb_dat_r <= WORD_ZERO;
      endcase
  end

  // Control register; the cold reset engages the OS lock and the warm reset does not.
  // Only byte lane 0 carries control bits, so a write needs sel[0].
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_r <= CTRL_RST; // RQ13 RQ15
    else if (wb_wr && (wb_adr == OFF_CTRL))
      ctrl_r <= wb_dat_i[CTRL_W-1:0];
  end

  // Interrupt enable register.
  always_ff @(posedge clk)
  begin
    if (rst)
      ev_en_r <= EV_RST;
    else if (wb_wr && (wb_adr == OFF_IRQ_EN))
      ev_en_r <= wb_dat_i[NEV-1:0];
  end

  // Sticky interrupt status; a new event wins over a clear in the same cycle.
  assign ev_set[EV_SDAD] = debug_access_disabled_condition_hit; // RQ6
  assign ev_set[EV_REJ] = apb_take && rejected;
  assign ev_set[EV_WP] = wp_hit;
  assign ev_clr = (wb_wr && (wb_adr == OFF_IRQ_CLR)) ? wb_dat_i[NEV-1:0] : EV_RST;

  // Clear bits are applied first and new events are ORed in after, so no event is lost.

  always_ff @(posedge clk)
  begin
    if (rst)
      ev_st_r <= EV_RST;
    else
      ev_st_r <= (ev_st_r & ~ev_clr) | ev_set;
  end

  // Level interrupt while any enabled status bit stands.
  assign irq = |(ev_st_r & ev_en_r);

endmodule : dag_gate
`default_nettype wire

// File: dag_gate_monitor.sv
// Port assertions for the debug access gate.
`timescale 1ns/1ps
`default_nettype none
module dag_gate_monitor
  import dag_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic warm_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic core_power_off,
  input wire logic mem_valid,
  input wire logic [2:0] mem_kind,
  input wire logic wp_match,
  input wire logic [7:0] mem_tag,
  input wire logic wp_event,
  input wire logic [7:0] wp_tag,
  input wire logic dbg_ignore,
  input wire logic dbg_exception,
  input wire logic dbg_halt
);
  // Every check runs on the one clock under the cold reset.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_off; psel && penable && !pready && core_power_off |=> pslverr; endproperty
  a_off: assert property (p_off) else $error("no error when off");
  property p_rej; pready && pslverr |-> prdata == 32'h0; endproperty
  a_rej: assert property (p_rej) else $error("data on refusal");
  property p_one_rdy; pready |=> !pready; endproperty
  a_one_rdy: assert property (p_one_rdy) else $error("ready too long");
  property p_wp; mem_valid && wp_match && warm_reset_n && !(mem_kind inside {K_HINT, K_CLEAN})
    |=> wp_event && wp_tag == $past(mem_tag); endproperty
  a_wp: assert property (p_wp) else $error("missed watchpoint");
  property p_nowp; mem_valid && mem_kind inside {K_HINT, K_CLEAN} |=> !wp_event; endproperty
  a_nowp: assert property (p_nowp) else $error("watchpoint on hint");
  property p_one; wp_event |-> $onehot({dbg_ignore, dbg_exception, dbg_halt}); endproperty
  a_one: assert property (p_one) else $error("response not single");
  property p_quiet; !wp_event |-> !(dbg_ignore || dbg_exception || dbg_halt); endproperty
  a_quiet: assert property (p_quiet) else $error("stray response");
  // Main scenarios reached.
  c_err: cover property (pready && pslverr);
  c_ok: cover property (pready && !pslverr);
  c_halt: cover property (dbg_halt);
  c_exc: cover property (dbg_exception);
endmodule : dag_gate_monitor
bind dag_gate dag_gate_monitor i_dag_gate_monitor (.clk, .rst, .warm_reset_n, .psel, .penable, .pready, .pslverr,
  .prdata, .core_power_off, .mem_valid, .mem_kind, .wp_match, .mem_tag, .wp_event, .wp_tag, .dbg_ignore,
  .dbg_exception, .dbg_halt);
`default_nettype wire

// File: dag_host.sv
// Behavioural external debugger on the debug port.
`timescale 1ns/1ps
`default_nettype none
module dag_host
  import dag_pkg::*;
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_AW-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // The port is idle until the first transfer.
  initial
  begin
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = 32'h0;
  end
  // Setup, access, hold until ready; released fields flip so stale values never pass.
  task xfer(input logic w, input logic [1:0] i, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {8'h00, i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : dag_host
`default_nettype wire

// File: dag_gate_bench.sv
// Self-checking bench for the debug access gate.
`timescale 1ns/1ps
`default_nettype none
module dag_gate_bench
  import dag_pkg::*;
;
  logic clk, rst, warm_reset_n, wb_cyc, wb_stb, wb_we, wb_ack, irq, psel, penable, pwrite, pready, pslverr, e;
  logic core_power_off, external_access_authorised, mem_valid, wp_match, wp_event, dbg_ignore, dbg_exception, dbg_halt;
  logic [7:0] wb_adr, mem_tag, wp_tag;
  logic [3:0] wb_sel, k;
  logic [2:0] mem_kind;
  logic [APB_AW-1:0] paddr;
  logic [31:0] wb_dat_i, wb_dat_o, pwdata, prdata, q;
  logic [31:0] cv [2] = '{32'h2, 32'h1};
  logic [31:0] sv [2] = '{32'h10, 32'h08};
  logic [31:0] mv [3] = '{32'h8, 32'h0, 32'h5};
  int n_fail = 0;
  int compares = 0;
  dag_gate i_dag_gate (.clk, .rst, .warm_reset_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_i, .wb_dat_o,
    .wb_ack, .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_power_off,
    .external_access_authorised, .mem_valid, .mem_kind, .wp_match, .mem_tag, .wp_event, .wp_tag, .dbg_ignore,
    .dbg_exception, .dbg_halt);
  dag_host i_dag_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // Counts a comparison and reports a mismatch.
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // One classic bus cycle, held until ack is sampled.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc, wb_stb, wb_we} <= {2'h3, w};
    wb_adr <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'h0;
  endtask : wb
  // Debug port transfer; the answer code is always checked, read data on every read.
  task ap(input logic w, input logic [1:0] i, input logic [31:0] d, input logic xe, input logic [31:0] xq);
    i_dag_host.xfer(w, i, d, q, e);
    chk("pslverr", e, xe);
    if (!w)
      chk("prdata", q, xq);
  endtask : ap
  // Presents one matching core operation and waits for its event cycle.
  task op(input logic [2:0] kd);
    @(posedge clk);
    {mem_valid, mem_kind, mem_tag} <= {1'b1, kd, 5'h0, kd};
    @(posedge clk);
    mem_valid <= 1'b0;
    @(posedge clk);
  endtask : op
  // Prints the verdict and ends the run.
  task stop_test;
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Clock of 25 ns.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cuts a hang short.
  initial
  begin
    #50000;
    n_fail++;
    stop_test();
  end
  // Main sequence.
  initial
  begin
    {rst, warm_reset_n, wb_cyc, wb_stb, wb_we, mem_valid, core_power_off} = 7'h60;
    {wb_adr, mem_tag, mem_kind, wb_dat_i} = '0;
    {wb_sel, wp_match, external_access_authorised} = 6'h3f;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl", q, 32'h1);
    ap(1'b1, 2'h1, 32'h5a, 1'b1, 32'h0);
    wb(1'b1, OFF_CTRL, 32'h0);
    wb(1'b1, OFF_IRQ_EN, 32'h3);
    ap(1'b1, 2'h1, 32'h5a, 1'b0, 32'h0);
    ap(1'b0, 2'h1, 32'h0, 1'b0, 32'h5a);
    external_access_authorised <= 1'b0;
    ap(1'b1, 2'h1, 32'h33, 1'b1, 32'h0);
    wb(1'b0, OFF_STAT, 32'h0);
    chk("stat", q, 32'h1);
    @(negedge clk);
    chk("irq", irq, 32'h1);
    @(posedge clk);
    external_access_authorised <= 1'b1;
    ap(1'b0, 2'h1, 32'h0, 1'b0, 32'h5a);
    ap(1'b0, 2'h0, 32'h0, 1'b0, 32'h5);
    external_access_authorised <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, OFF_CTRL, cv[i]);
      ap(1'b0, 2'h1, 32'h0, 1'b1, 32'h0);
      wb(1'b0, OFF_STAT, 32'h0);
      chk("lock", q, sv[i]);
    end
    wb(1'b1, OFF_CTRL, 32'h0);
    core_power_off <= 1'b1;
    ap(1'b0, 2'h0, 32'h0, 1'b1, 32'h0);
    wb(1'b0, OFF_STAT, 32'h0);
    chk("off", q, 32'h2);
    core_power_off <= 1'b0;
    wb(1'b1, OFF_IRQ_CLR, 32'h7);
    wb(1'b1, OFF_IRQ_EN, 32'h0);
    ap(1'b0, 2'h1, 32'h0, 1'b1, 32'h0);
    @(negedge clk);
    chk("mask", irq, 32'h0);
    wb(1'b0, OFF_IRQ_ST, 32'h0);
    chk("irq_st", q, 32'h3);
    wb(1'b1, OFF_IRQ_EN, 32'h2);
    @(negedge clk);
    chk("irq_en", irq, 32'h1);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    external_access_authorised <= 1'b1;
    wb(1'b1, OFF_CTRL, 32'h4);
    warm_reset_n <= 1'b0;
    @(posedge clk);
    warm_reset_n <= 1'b1;
    wb(1'b0, OFF_CTRL, 32'h0);
    chk("warm", q, 32'h4);
    wb(1'b0, OFF_STAT, 32'h0);
    chk("warm_st", q, 32'h5);
    for (k = 4'h0; k < 4'h8; k++)
    begin
      op(k[2:0]);
      chk("wp", wp_event, {31'h0, k != 4'h2 && k != 4'h3});
      chk("halt", dbg_halt, {31'h0, k != 4'h2 && k != 4'h3});
      chk("tag", wp_tag, (k != 4'h2 && k != 4'h3) ? {29'h0, k[2:0]} : 32'h0);
    end
    for (int j = 0; j < 3; j++)
    begin
      wb(1'b1, OFF_CTRL, mv[j]);
      op(3'h1);
      chk("exc", dbg_exception, {31'h0, j == 0});
      chk("ignore", dbg_ignore, {31'h0, j != 0});
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, OFF_CTRL, 32'h0);
    chk("cold", q, 32'h1);
    wb(1'b0, OFF_STAT, 32'h0);
    chk("cold_st", q, 32'hc);
    stop_test();
  end
endmodule : dag_gate_bench
`default_nettype wire
